// >>> hdl/ddpc_cfg.svh
// Constants for the dual potentiometer control block.
`ifndef DDPC_CFG_SVH
`define DDPC_CFG_SVH

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define DDPC_WIPER_W    6
`define DDPC_TAPS       64
`define DDPC_WIPER_MAX  6'h3F
`define DDPC_WIPER_MIN  6'h00
`define DDPC_WIPER_RST  6'h00
`define DDPC_NV_BLANK   6'h00
`define DDPC_CNT_ACK    4'h8
`define DDPC_CNT_REL    4'h9

// ----------------------------------------------------------------------
// Address byte: upper nibble device type (arbitrary value), lower nibble select
// ----------------------------------------------------------------------
`define DDPC_DEV_TYPE   4'h5

// ----------------------------------------------------------------------
// Instruction byte: [7:4] opcode, [3:2] stored slot, [0] potentiometer
// ----------------------------------------------------------------------
`define DDPC_OP_RD_WIPER 4'h9
`define DDPC_OP_WR_WIPER 4'hA
`define DDPC_OP_RD_STORE 4'hB
`define DDPC_OP_WR_STORE 4'hC
`define DDPC_OP_TO_WIPER 4'hD
`define DDPC_OP_TO_STORE 4'hE
`define DDPC_OP_INCDEC   4'h2

`endif

// >>> hdl/ddpc_pkg.sv
// Types shared by the dual potentiometer control block.
package ddpc_pkg;

  // --------------------------------------------------------------------
  // Serial engine states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RECALL,
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_INCDEC
  } ddpc_state_type;

endpackage : ddpc_pkg

// >>> hdl/ddpc_top.sv
// Dual 64-tap potentiometer control with a 2-wire serial slave.
// Functional notes
// [R1] Each of the two potentiometers has its own 6-bit wiper setting register choosing its tap.
// [R2] Each potentiometer has four 6-bit stored settings that keep their value across rst_n.
// [R3] Leaving reset, the first stored setting of each pot is copied into its wiper setting.
// [R4] With write_guard_n low, stored settings never change though wiper writes still work.
// [R5] With write_guard_n high, every register may be read and written, stored ones included.
// [R6] The device acknowledges only when the address byte carries its four select inputs.
// [R7] Each array has 63 elements and exactly one of its 64 taps is selected at any time.
// [R8] The bus master can read and write wiper and stored settings over the serial bus.
// [R9] Instructions copy between a pot's wiper setting and any of its own stored settings.
// [R10] An instruction enters a mode where each received bit steps the wiper up or down.
// [R11] The data line is only ever pulled low or released, never driven high.
// [R12] The bus master supplies the serial clock that times every transfer.
// [R13] Setting zero selects the low-end tap and setting sixty-three the high-end tap.
// [R14] A guarded stored write is still acknowledged but leaves the stored value unchanged.
`timescale 1ns/1ps
`include "ddpc_cfg.svh"

module ddpc_top
  import ddpc_pkg::*;
#(
  parameter int POTS  = 2,
  parameter int SLOTS = 4
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              scl,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe,
  input  wire logic                              addr_select_bit0,
  input  wire logic                              addr_select_bit1,
  input  wire logic                              addr_select_bit2,
  input  wire logic                              addr_select_bit3,
  input  wire logic                              write_guard_n,
  output logic [POTS-1:0][`DDPC_WIPER_W-1:0]     wiper_setting_reg,
  output logic [POTS-1:0][`DDPC_TAPS-1:0]        tap_sel,
  output logic                                   incdec_mode
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (POTS != 2 || SLOTS != 4) begin : g_bad_param
    $error("ddpc_top: instruction encoding serves exactly 2 pots of 4 slots");
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  ddpc_state_type                          state_r, state_nxt, next_r, next_nxt;
  logic [3:0]                              cnt_r, cnt_nxt;
  logic [7:0]                              shift_r, shift_nxt;
  logic [7:0]                              instr_r, instr_nxt;
  logic                                    scl_q_r, sda_q_r;
  logic                                    sda_oe_r, sda_oe_nxt;
  logic [POTS-1:0][`DDPC_WIPER_W-1:0]      wiper_r, wiper_nxt;
  logic [POTS*SLOTS-1:0][`DDPC_WIPER_W-1:0] store_r, store_nxt;
  logic [POTS-1:0][`DDPC_TAPS-1:0]         tap_r, tap_nxt;
  logic                                    scl_rise, scl_fall, start_ev, stop_ev;
  logic [3:0]                              addr_sel;
  logic [3:0]                              op;
  logic                                    pot;
  logic [2:0]                              slot_ix;
  logic [`DDPC_WIPER_W-1:0]                rd_data;

  // Bus events, with the master's clock sampled as an ordinary input.
  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_ev = scl & scl_q_r & sda_q_r & ~sda_i;
  assign stop_ev  = scl & scl_q_r & ~sda_q_r & sda_i; // R12
  assign addr_sel = {addr_select_bit3, addr_select_bit2, addr_select_bit1, addr_select_bit0};
  assign op       = instr_r[7:4];
  assign pot      = instr_r[0];
  assign slot_ix  = {instr_r[0], instr_r[3:2]};
  assign rd_data  = (op == `DDPC_OP_RD_STORE) ? store_r[slot_ix] : wiper_r[pot];

  // --------------------------------------------------------------------
  // Serial engine and register bank
  // --------------------------------------------------------------------
  // Computes the next engine state, line drive and register contents.
  always_comb begin
    state_nxt  = state_r;
    next_nxt   = next_r;
    cnt_nxt    = cnt_r;
    shift_nxt  = shift_r;
    instr_nxt  = instr_r;
    sda_oe_nxt = sda_oe_r;
    wiper_nxt  = wiper_r;
    store_nxt  = store_r;
    if (state_r == ST_RECALL) begin
      for (int p = 0; p < POTS; p++) begin
        wiper_nxt[p] = store_r[p*SLOTS]; // R3
      end
      state_nxt = ST_IDLE;
    end else if (start_ev) begin
      state_nxt  = ST_ADDR;
      cnt_nxt    = 4'h0;
      sda_oe_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt  = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (state_r == ST_INCDEC) begin
      if (scl_rise && sda_i && wiper_r[pot] != `DDPC_WIPER_MAX) begin
        wiper_nxt[pot] = wiper_r[pot] + 6'h01; // R10
      end else if (scl_rise && !sda_i && wiper_r[pot] != `DDPC_WIPER_MIN) begin
        wiper_nxt[pot] = wiper_r[pot] - 6'h01; // R10
      end
    end else if (state_r == ST_RDATA) begin
      if (scl_rise && cnt_r == `DDPC_CNT_ACK) begin
        if (sda_i) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt   = 4'h0;
          shift_nxt = {2'b00, rd_data};
        end
      end else if (scl_rise) begin
        cnt_nxt = cnt_r + 4'h1;
      end else if (scl_fall && cnt_r == `DDPC_CNT_ACK) begin
        sda_oe_nxt = 1'b0;
      end else if (scl_fall) begin
        sda_oe_nxt = ~shift_r[3'(7 - cnt_r)]; // R11
      end
    end else if (state_r != ST_IDLE) begin
      if (scl_rise && cnt_r < `DDPC_CNT_ACK) begin
        shift_nxt = {shift_r[6:0], sda_i};
        cnt_nxt   = cnt_r + 4'h1;
      end else if (scl_fall && cnt_r == `DDPC_CNT_REL) begin
        cnt_nxt    = 4'h0;
        state_nxt  = next_r;
        sda_oe_nxt = 1'b0;
        if (next_r == ST_RDATA) begin
          shift_nxt  = {2'b00, rd_data}; // R8
          sda_oe_nxt = ~shift_nxt[7]; // R11
        end
      end else if (scl_fall && cnt_r == `DDPC_CNT_ACK) begin
        cnt_nxt    = `DDPC_CNT_REL;
        sda_oe_nxt = 1'b1;
        case (state_r)
          ST_ADDR: begin
            if (shift_r == {`DDPC_DEV_TYPE, addr_sel}) begin
              next_nxt = ST_INSTR; // R6
            end else begin
              state_nxt  = ST_IDLE; // R6
              sda_oe_nxt = 1'b0;
            end
          end
          ST_INSTR: begin
            instr_nxt = shift_r;
            case (shift_r[7:4])
              `DDPC_OP_RD_WIPER, `DDPC_OP_RD_STORE: next_nxt = ST_RDATA;
              `DDPC_OP_WR_WIPER, `DDPC_OP_WR_STORE: next_nxt = ST_WDATA;
              `DDPC_OP_INCDEC:                      next_nxt = ST_INCDEC;
              `DDPC_OP_TO_WIPER: begin
                wiper_nxt[shift_r[0]] = store_r[{shift_r[0], shift_r[3:2]}]; // R9
                next_nxt              = ST_IDLE;
              end
              `DDPC_OP_TO_STORE: begin
                if (write_guard_n) begin
                  store_nxt[{shift_r[0], shift_r[3:2]}] = wiper_r[shift_r[0]]; // R9 R5
                end
                next_nxt = ST_IDLE; // R14
              end
              default: begin
                state_nxt  = ST_IDLE;
                sda_oe_nxt = 1'b0;
              end
            endcase
          end
          ST_WDATA: begin
            if (op == `DDPC_OP_WR_WIPER) begin
              wiper_nxt[pot] = shift_r[`DDPC_WIPER_W-1:0]; // R8 R4
            end else if (write_guard_n) begin
              store_nxt[slot_ix] = shift_r[`DDPC_WIPER_W-1:0]; // R8 R5
            end
            next_nxt = ST_WDATA; // R14
          end
          default: begin
            state_nxt  = ST_IDLE;
            sda_oe_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // Registers the engine; stored settings are kept across rst_n.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r  <= ST_RECALL;
      next_r   <= ST_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      instr_r  <= 8'h00;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      sda_oe_r <= 1'b0;
      wiper_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      next_r   <= next_nxt;
      cnt_r    <= cnt_nxt;
      shift_r  <= shift_nxt;
      instr_r  <= instr_nxt;
      scl_q_r  <= scl;
      sda_q_r  <= sda_i;
      sda_oe_r <= sda_oe_nxt;
      wiper_r  <= wiper_nxt; // R1
    end
  end

  // Non-volatile cells: blank on first power-up only, untouched by later resets.
  // The marker starts clear at power-up, so the first reset is known to be the first.
  logic nv_init_r = 1'b0;
  always_ff @(posedge clk) begin
    if (!rst_n && !nv_init_r) begin
      store_r <= '0;
    end else if (rst_n) begin
      store_r <= store_nxt; // R2
    end
  end

  // --------------------------------------------------------------------
  // Tap decode, one group per potentiometer
  // --------------------------------------------------------------------
  for (genvar p = 0; p < POTS; p++) begin : g_tap
    // One-hot tap select, tap 0 at the low end of the array.
    always_comb begin
      tap_nxt[p] = '0;
      tap_nxt[p][wiper_nxt[p]] = 1'b1; // R7 R13
    end
    // Registers the tap select so the switch drive is glitch free.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        tap_r[p] <= {{(`DDPC_TAPS-1){1'b0}}, 1'b1};
      end else begin
        tap_r[p] <= tap_nxt[p];
      end
    end
  end

  // Marks the first reset seen so later resets keep the stored cells.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nv_init_r <= 1'b1;
    end
  end

  // Output flops.
  logic sda_o_r, incdec_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_o_r  <= 1'b0;
      incdec_r <= 1'b0;
    end else begin
      sda_o_r  <= 1'b0; // R11
      incdec_r <= (state_nxt == ST_INCDEC);
    end
  end

  assign sda_o             = sda_o_r;
  assign sda_oe            = sda_oe_r;
  assign wiper_setting_reg = wiper_r;
  assign tap_sel           = tap_r;
  assign incdec_mode       = incdec_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  recall_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    state_r == ST_RECALL |=> wiper_r[1] == $past(store_r[SLOTS]) && state_r == ST_IDLE)
    else $error("wiper not recalled from first stored setting");
  guard_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    !write_guard_n |=> $stable(store_r))
    else $error("stored setting changed while guarded");
  one_tap_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    $onehot(tap_r[0]) && $onehot(tap_r[1]))
    else $error("tap select not one-hot");
  tap_match_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
    state_r != ST_RECALL |-> tap_r[0][wiper_r[0]] && tap_r[1][wiper_r[1]])
    else $error("tap select does not follow wiper");
  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    state_r == ST_ADDR && $rose(sda_oe_r) |-> shift_r[3:0] == addr_sel)
    else $error("acknowledged a foreign address");
  drain_only_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    sda_o == 1'b0)
    else $error("data line driven high");
  step_up_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    state_r == ST_INCDEC && scl_rise && sda_i && !start_ev && !stop_ev
      && wiper_r[pot] != `DDPC_WIPER_MAX
    |=> wiper_r[$past(pot)] == 6'($past(wiper_r[pot]) + 6'h01))
    else $error("increment step missing");
  wiper_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    state_r == ST_WDATA && scl_fall && cnt_r == `DDPC_CNT_ACK && op == `DDPC_OP_WR_WIPER
      && !start_ev && !stop_ev
    |=> wiper_r[$past(pot)] == $past(shift_r[`DDPC_WIPER_W-1:0]) ##1 sda_oe_r)
    else $error("wiper write lost");
  stop_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    stop_ev && state_r != ST_RECALL |=> !sda_oe_r [*2])
    else $error("line held after stop");

endmodule : ddpc_top

// >>> verification/ddpc_master_model.sv
// Behavioural 2-wire bus master that faces the block's serial side.
`timescale 1ns/1ps

module ddpc_master_model (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);

  // The bus idles with the clock high and the data line released.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Waits falling clock edges, so every bus change lands off the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Start condition: data falls while the serial clock is high.
  task automatic start();
    sda_low = 1'b0;
    scl     = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start

  // One bit: data is set while the clock is low and sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask : bit_io

  // Sends a byte MSB first, then releases the line for the answer bit.
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_out

  // Receives a byte MSB first and ends it with a not-acknowledge.
  task automatic byte_in(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
  endtask : byte_in

  // Stop condition: data rises while the serial clock is high.
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask : stop

endmodule : ddpc_master_model

// >>> verification/ddpc_top_test.sv
// Self-checking testbench for the dual potentiometer control block.
`timescale 1ns/1ps
`include "ddpc_cfg.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end

module ddpc_top_test;
  logic             clk, rst_n, scl, sda_low, sda_line, write_guard_n;
  logic             sda_o, sda_oe, incdec_mode;
  logic [3:0]       addr_sel;
  logic [1:0][5:0]  wiper;
  logic [1:0][63:0] tap_sel;
  int               err_count, total_checks, cycles;

  // The data line has a pull-up and is low while either party pulls it.
  assign sda_line = ~(sda_oe | sda_low);

  // Clock of 25 ns and a cycle count that cuts a hang short.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // The device never drives the data line high.
  always @(negedge clk) if (rst_n) `CHK("sda_o", 1'b0, sda_o)

  ddpc_top ddpc_top_i (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_select_bit0(addr_sel[0]), .addr_select_bit1(addr_sel[1]),
    .addr_select_bit2(addr_sel[2]), .addr_select_bit3(addr_sel[3]),
    .write_guard_n(write_guard_n), .wiper_setting_reg(wiper), .tap_sel(tap_sel),
    .incdec_mode(incdec_mode));
  ddpc_master_model ddpc_master_model_i (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda_line));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  // Builds an instruction byte from opcode, slot and potentiometer.
  function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] sl, input logic p);
    return {op, sl, 1'b0, p};
  endfunction : ins

  // Compares one pot's wiper setting and its one-hot tap selection.
  task automatic chk_pot(input int p, input logic [5:0] v);
    `CHK("wiper", v, wiper[p])
    `CHK("tap_sel", 64'h1 << v, tap_sel[p])
  endtask : chk_pot

  // Addressed transfer; mode 1 writes a data byte, mode 2 reads one.
  task automatic xfer(input logic [7:0] i, input int mode, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic ack;
    rd = 8'h00;
    ddpc_master_model_i.start();
    ddpc_master_model_i.byte_out({`DDPC_DEV_TYPE, addr_sel}, ack);
    `CHK("addr ack", 1'b1, ack)
    ddpc_master_model_i.byte_out(i, ack);
    `CHK("instr ack", 1'b1, ack)
    if (mode == 1) begin
      ddpc_master_model_i.byte_out(wd, ack);
      `CHK("data ack", 1'b1, ack)
    end
    if (mode == 2) ddpc_master_model_i.byte_in(rd);
    ddpc_master_model_i.stop();
  endtask : xfer

  // Resets the block and checks the recalled first stored settings.
  task automatic reset_recall(input logic [5:0] v0, input logic [5:0] v1);
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_pot(0, v0);
    chk_pot(1, v1);
  endtask : reset_recall

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Both ends of the wiper range, pots independent, and a read back.
  task automatic wiper_ends();
    logic [7:0] rd;
    xfer(ins(`DDPC_OP_WR_WIPER, 2'h0, 1'b0), 1, 8'h3F, rd);
    xfer(ins(`DDPC_OP_WR_WIPER, 2'h0, 1'b1), 1, 8'h00, rd);
    chk_pot(0, 6'h3F);
    chk_pot(1, 6'h00);
    xfer(ins(`DDPC_OP_RD_WIPER, 2'h0, 1'b0), 2, 8'h00, rd);
    `CHK("wiper read", 8'h3F, rd)
  endtask : wiper_ends

  // A foreign address gets no answer; a new select value is honoured.
  task automatic addr_match();
    logic       ack;
    logic [7:0] rd;
    ddpc_master_model_i.start();
    ddpc_master_model_i.byte_out({`DDPC_DEV_TYPE, ~addr_sel}, ack);
    `CHK("foreign ack", 1'b0, ack)
    ddpc_master_model_i.stop();
    addr_sel = 4'hC;
    xfer(ins(`DDPC_OP_RD_WIPER, 2'h0, 1'b0), 2, 8'h00, rd);
    `CHK("new addr read", 8'h3F, rd)
  endtask : addr_match

  // Guarded stored writes are acknowledged but dropped; wiper writes pass.
  task automatic guard_store();
    logic [7:0] rd;
    write_guard_n = 1'b0;
    xfer(ins(`DDPC_OP_WR_STORE, 2'h1, 1'b0), 1, 8'h15, rd);
    xfer(ins(`DDPC_OP_RD_STORE, 2'h1, 1'b0), 2, 8'h00, rd);
    `CHK("guarded store", 8'h00, rd)
    xfer(ins(`DDPC_OP_WR_WIPER, 2'h0, 1'b1), 1, 8'h2A, rd);
    chk_pot(1, 6'h2A);
    write_guard_n = 1'b1;
    xfer(ins(`DDPC_OP_WR_STORE, 2'h1, 1'b0), 1, 8'h15, rd);
    xfer(ins(`DDPC_OP_RD_STORE, 2'h1, 1'b0), 2, 8'h00, rd);
    `CHK("open store", 8'h15, rd)
  endtask : guard_store

  // Copies stored to wiper and wiper to stored on pot 1.
  task automatic copy_ops();
    logic [7:0] rd;
    xfer(ins(`DDPC_OP_WR_STORE, 2'h2, 1'b1), 1, 8'h07, rd);
    xfer(ins(`DDPC_OP_TO_WIPER, 2'h2, 1'b1), 0, 8'h00, rd);
    chk_pot(1, 6'h07);
    xfer(ins(`DDPC_OP_WR_WIPER, 2'h0, 1'b1), 1, 8'h31, rd);
    xfer(ins(`DDPC_OP_TO_STORE, 2'h3, 1'b1), 0, 8'h00, rd);
    xfer(ins(`DDPC_OP_RD_STORE, 2'h3, 1'b1), 2, 8'h00, rd);
    `CHK("copied store", 8'h31, rd)
    xfer(ins(`DDPC_OP_WR_STORE, 2'h0, 1'b0), 1, 8'h22, rd);
    xfer(ins(`DDPC_OP_WR_STORE, 2'h0, 1'b1), 1, 8'h11, rd);
    chk_pot(0, 6'h3F);
  endtask : copy_ops

  // Steps pot 0 from the top: up saturates, down twice, up once; the stop's
  // clock rise comes with the data line low, so it counts one more step down.
  task automatic incdec();
    logic       ack;
    logic [7:0] rd;
    logic [3:0] steps;
    steps = 4'b1001;
    ddpc_master_model_i.start();
    ddpc_master_model_i.byte_out({`DDPC_DEV_TYPE, addr_sel}, ack);
    ddpc_master_model_i.byte_out(ins(`DDPC_OP_INCDEC, 2'h0, 1'b0), ack);
    `CHK("incdec ack", 1'b1, ack)
    for (int i = 3; i >= 0; i--) ddpc_master_model_i.bit_io(steps[i], rd[0]);
    `CHK("incdec_mode", 1'b1, incdec_mode)
    ddpc_master_model_i.stop();
    `CHK("incdec_mode off", 1'b0, incdec_mode)
    chk_pot(0, 6'h3D);
  endtask : incdec

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Main sequence: power-up recall, scenarios, then recall after a reset.
  initial begin
    clk           = 1'b0;
    rst_n         = 1'b0;
    write_guard_n = 1'b1;
    addr_sel      = 4'h6;
    reset_recall(6'h00, 6'h00);
    wiper_ends();
    addr_match();
    guard_store();
    copy_ops();
    incdec();
    reset_recall(6'h22, 6'h11);
    wrap_up();
  end

endmodule : ddpc_top_test
